// >>> verilog/hds_pkg.sv
package hds_pkg;
    localparam int       MAX_PORTS      = 255;
    localparam int       MAP_W          = MAX_PORTS + 1;
    localparam int       FIXED_BYTES    = 7;
    localparam logic [7:0] OFS_LENGTH   = 8'h00;
    localparam logic [7:0] OFS_TYPE     = 8'h01;
    localparam logic [7:0] OFS_NPORTS   = 8'h02;
    localparam logic [7:0] OFS_CHAR_LO  = 8'h03;
    localparam logic [7:0] OFS_CHAR_HI  = 8'h04;
    localparam logic [7:0] OFS_PWR_GOOD = 8'h05;
    localparam logic [7:0] OFS_CURRENT  = 8'h06;
    localparam logic [7:0] OFS_MAP      = 8'h07;
    localparam logic [7:0] HUB_DESC_TYPE = 8'h29;
    localparam logic [7:0] CHAR_HI_RSVD  = 8'h00;
    localparam logic [7:0] PWR_MASK_BYTE = 8'hFF;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam int       PWR_GOOD_UNIT_MS = 2;
    localparam int       CHAR_PWR_LSB   = 0;
    localparam int       CHAR_COMPOUND  = 2;
    localparam int       CHAR_OC_LSB    = 3;
    localparam int       CHAR_TT_LSB    = 5;
    localparam int       CHAR_IND       = 7;
    localparam logic [1:0] OC_GLOBAL    = 2'h0;

    typedef enum logic [1:0] {
        HDS_IDLE,
        HDS_ADDR,
        HDS_LOAD,
        HDS_HOLD
    } hds_state_t;
endpackage

// >>> verilog/hds_img_if.sv
`timescale 1ns/1ps
interface hds_img_if #(
    parameter int MAP_W = hds_pkg::MAP_W
);
    logic [7:0]       addr;
    logic [7:0]       nports;
    logic [7:0]       char_lo;
    logic [7:0]       pwr_good;
    logic [7:0]       current;
    logic [7:0]       length;
    logic [MAP_W-1:0] rem_map;
    logic [7:0]       rd_data;

    modport ctrl (output addr, nports, char_lo, pwr_good, current, length,
                  rem_map, input rd_data);
    modport img  (input addr, nports, char_lo, pwr_good, current, length,
                  rem_map, output rd_data);
endinterface

// >>> verilog/hds_image.sv
`timescale 1ns/1ps
module hds_image (
    input  wire logic clk,
    input  wire logic rst_n,
    hds_img_if.img    im
);
    localparam int MAP_BYTES = hds_pkg::MAP_W / 8;

    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic [7:0] rel;
    logic [7:0] rem_bytes;
    logic [4:0] map_idx;

    assign rem_bytes = (im.nports >> 3) + 8'h01;
    assign rel       = im.addr - hds_pkg::OFS_MAP;
    assign map_idx   = rel[4:0];

    always_comb begin
        rd_data_nxt = hds_pkg::BYTE_RST;
        case (im.addr)
            hds_pkg::OFS_LENGTH:   rd_data_nxt = im.length;
            hds_pkg::OFS_TYPE:     rd_data_nxt = hds_pkg::HUB_DESC_TYPE;
            hds_pkg::OFS_NPORTS:   rd_data_nxt = im.nports;
            hds_pkg::OFS_CHAR_LO:  rd_data_nxt = im.char_lo;
            hds_pkg::OFS_CHAR_HI:  rd_data_nxt = hds_pkg::CHAR_HI_RSVD;
            hds_pkg::OFS_PWR_GOOD: rd_data_nxt = im.pwr_good;
            hds_pkg::OFS_CURRENT:  rd_data_nxt = im.current;
            default: begin
                if (rel < rem_bytes && rel < 8'(MAP_BYTES)) begin
                    rd_data_nxt = im.rem_map[map_idx*8 +: 8];
                end else begin
                    // legacy mask bytes, pad bits included
                    rd_data_nxt = hds_pkg::PWR_MASK_BYTE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_r <= hds_pkg::BYTE_RST;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign im.rd_data = rd_data_r;
endmodule // hds_image

// >>> verilog/hds_desc_source.sv
`timescale 1ns/1ps
// Operation
// - byte 0 holds the total descriptor length, counting itself
// - byte 1 holds hub descriptor type code 29h
// - byte 2 holds the number of downstream ports
// - characteristics bits 1:0 give the power switching scheme
// - characteristics bit 2 is set for a compound device
// - characteristics bits 4:3 give the over-current reporting mode
// - no-protection code only allowed for bus-powered hubs
// - characteristics bits 6:5 give translator think time, 8 to 32 bits
// - bit 7 flags port indicators; without it indicator requests do nothing
// - byte 5 holds power-on to power-good time in 2 ms units
// - byte 6 holds hub controller current in mA
// - removable bitmap from byte 7, bit n is port n, bit 0 reserved
// - bitmap bit 0 means removable, 1 means permanently attached
// - bitmap bits for ports that do not exist read zero
// - legacy power mask follows, one bit per port, padded, all ones
module hds_desc_source #(
    parameter int MAX_PORTS = hds_pkg::MAX_PORTS
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       cfg_num_ports,
    input  wire logic [1:0]       cfg_power_mode,
    input  wire logic             cfg_compound,
    input  wire logic [1:0]       cfg_oc_mode,
    input  wire logic             cfg_bus_powered,
    input  wire logic [1:0]       cfg_tt_think,
    input  wire logic             cfg_port_ind,
    input  wire logic [7:0]       cfg_pwr_good_time,
    input  wire logic [7:0]       cfg_ctrl_current,
    input  wire logic [MAX_PORTS:0] cfg_fixed_ports,
    input  wire logic             fetch_start,
    input  wire logic [15:0]      fetch_len,
    input  wire logic             byte_ready,
    output logic                  byte_valid,
    output logic [7:0]            byte_data,
    output logic                  byte_last,
    output logic                  fetch_busy,
    output logic [7:0]            desc_length,
    input  wire logic             ind_req,
    input  wire logic [7:0]       ind_req_port,
    output logic                  ind_apply,
    output logic [7:0]            ind_port
);
    localparam int MAP_W = MAX_PORTS + 1;

    hds_img_if #(.MAP_W(MAP_W)) im ();

    hds_pkg::hds_state_t state_r;
    logic [7:0]       addr_r;
    logic [7:0]       left_r;
    logic [7:0]       nports_r;
    logic [7:0]       char_lo_r;
    logic [7:0]       pwr_good_r;
    logic [7:0]       current_r;
    logic [7:0]       length_r;
    logic [MAP_W-1:0] rem_map_r;
    logic [MAP_W-1:0] rem_map_nxt;
    logic [7:0]       char_lo_nxt;
    logic [1:0]       oc_eff;
    logic [7:0]       map_bytes_nxt;
    logic [7:0]       mask_bytes_nxt;
    logic [7:0]       len_nxt;
    logic [7:0]       cnt_nxt;
    logic             byte_valid_r;
    logic [7:0]       byte_data_r;
    logic             byte_last_r;
    logic             fetch_busy_r;
    logic [7:0]       desc_length_r;
    logic             ind_apply_r;
    logic [7:0]       ind_port_r;

    // existing ports keep their strap, all others and bit 0 read zero
    for (genvar i = 0; i < MAP_W; i++) begin : g_map
        assign rem_map_nxt[i] = (i != 0) && (i <= int'(cfg_num_ports)) &&
                                cfg_fixed_ports[i];
    end

    // a self-powered hub must not claim it has no protection
    assign oc_eff = (cfg_oc_mode[1] && !cfg_bus_powered) ?
                    hds_pkg::OC_GLOBAL : cfg_oc_mode;

    always_comb begin
        char_lo_nxt = hds_pkg::BYTE_RST;
        char_lo_nxt[hds_pkg::CHAR_PWR_LSB +: 2] = cfg_power_mode;
        char_lo_nxt[hds_pkg::CHAR_COMPOUND]     = cfg_compound;
        char_lo_nxt[hds_pkg::CHAR_OC_LSB +: 2]  = oc_eff;
        char_lo_nxt[hds_pkg::CHAR_TT_LSB +: 2]  = cfg_tt_think;
        char_lo_nxt[hds_pkg::CHAR_IND]          = cfg_port_ind;
    end

    // fixed part, removable bytes, then power mask bytes
    assign map_bytes_nxt  = (cfg_num_ports >> 3) + 8'h01;
    // the mask rounds up, so a partial byte is padded with ones
    assign mask_bytes_nxt = 8'((9'(cfg_num_ports) + 9'h007) >> 3);
    assign len_nxt        = 8'(hds_pkg::FIXED_BYTES) + map_bytes_nxt +
                            mask_bytes_nxt;
    // a zero request length leaves the block idle
    assign cnt_nxt = (fetch_len < {8'h00, len_nxt}) ?
                     fetch_len[7:0] : len_nxt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            desc_length_r <= hds_pkg::BYTE_RST;
        end else begin
            desc_length_r <= len_nxt;
        end
    end

    // snapshot keeps the image steady while a fetch is under way
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nports_r   <= hds_pkg::BYTE_RST;
            char_lo_r  <= hds_pkg::BYTE_RST;
            pwr_good_r <= hds_pkg::BYTE_RST;
            current_r  <= hds_pkg::BYTE_RST;
            length_r   <= hds_pkg::BYTE_RST;
            rem_map_r  <= '0;
        end else if (state_r == hds_pkg::HDS_IDLE && fetch_start) begin
            nports_r   <= cfg_num_ports;
            char_lo_r  <= char_lo_nxt;
            pwr_good_r <= cfg_pwr_good_time;
            current_r  <= cfg_ctrl_current;
            length_r   <= len_nxt;
            rem_map_r  <= rem_map_nxt;
        end
    end

    // each byte costs at least three cycles: address, image read, then offer until taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= hds_pkg::HDS_IDLE;
            addr_r       <= hds_pkg::OFS_LENGTH;
            left_r       <= hds_pkg::BYTE_RST;
            byte_valid_r <= 1'b0;
            byte_data_r  <= hds_pkg::BYTE_RST;
            byte_last_r  <= 1'b0;
            fetch_busy_r <= 1'b0;
        end else begin
            case (state_r)
                hds_pkg::HDS_IDLE: begin
                    if (fetch_start && cnt_nxt != 8'h00) begin
                        addr_r       <= hds_pkg::OFS_LENGTH;
                        left_r       <= cnt_nxt;
                        fetch_busy_r <= 1'b1;
                        state_r      <= hds_pkg::HDS_ADDR;
                    end
                end
                hds_pkg::HDS_ADDR: begin
                    state_r <= hds_pkg::HDS_LOAD;
                end
                hds_pkg::HDS_LOAD: begin
                    byte_data_r  <= im.rd_data;
                    byte_valid_r <= 1'b1;
                    byte_last_r  <= (left_r == 8'h01);
                    state_r      <= hds_pkg::HDS_HOLD;
                end
                // the byte stands until the consumer takes it
                hds_pkg::HDS_HOLD: begin
                    if (byte_ready) begin
                        byte_valid_r <= 1'b0;
                        byte_last_r  <= 1'b0;
                        left_r       <= left_r - 8'h01;
                        addr_r       <= addr_r + 8'h01;
                        if (byte_last_r) begin
                            fetch_busy_r <= 1'b0;
                            state_r      <= hds_pkg::HDS_IDLE;
                        end else begin
                            state_r <= hds_pkg::HDS_ADDR;
                        end
                    end
                end
                default: begin
                    state_r <= hds_pkg::HDS_IDLE;
                end
            endcase
        end
    end

    // indicator requests are dropped when indicators are not fitted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ind_apply_r <= 1'b0;
        end else begin
            ind_apply_r <= ind_req && cfg_port_ind;
        end
    end

    // the last accepted port stays put while requests are dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ind_port_r <= hds_pkg::BYTE_RST;
        end else if (ind_req && cfg_port_ind) begin
            ind_port_r <= ind_req_port;
        end
    end

    assign im.addr     = addr_r;
    assign im.nports   = nports_r;
    assign im.char_lo  = char_lo_r;
    assign im.pwr_good = pwr_good_r;
    assign im.current  = current_r;
    assign im.length   = length_r;
    assign im.rem_map  = rem_map_r;

    hds_image u_image (
        .clk   (clk),
        .rst_n (rst_n),
        .im    (im)
    );

    assign byte_valid  = byte_valid_r;
    assign byte_data   = byte_data_r;
    assign byte_last   = byte_last_r;
    assign fetch_busy  = fetch_busy_r;
    assign desc_length = desc_length_r;
    assign ind_apply   = ind_apply_r;
    assign ind_port    = ind_port_r;
endmodule // hds_desc_source

// >>> verif/hds_desc_checker.sv
`timescale 1ns/1ps
module hds_desc_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        fetch_start,
    input wire logic        byte_ready,
    input wire logic        byte_valid,
    input wire logic        byte_last,
    input wire logic        fetch_busy,
    input wire logic        cfg_compound,
    input wire logic        cfg_port_ind,
    input wire logic        cfg_bus_powered,
    input wire logic        ind_req,
    input wire logic        ind_apply,
    input wire logic [1:0]  cfg_power_mode,
    input wire logic [1:0]  cfg_oc_mode,
    input wire logic [1:0]  cfg_tt_think,
    input wire logic [7:0]  cfg_num_ports,
    input wire logic [7:0]  cfg_pwr_good_time,
    input wire logic [7:0]  cfg_ctrl_current,
    input wire logic [7:0]  byte_data,
    input wire logic [7:0]  desc_length,
    input wire logic [7:0]  ind_req_port,
    input wire logic [7:0]  ind_port,
    input wire logic [15:0] fetch_len
);
    logic [7:0]  idx_r;
    logic [15:0] cnt_r;
    wire         take = fetch_start && !fetch_busy && fetch_len != 16'h0000;
    wire [15:0]  dlen = {8'h00, desc_length};
    always_ff @(posedge clk) begin
        if (!rst_n || take) idx_r <= 8'h00;
        else if (byte_valid && byte_ready) idx_r <= idx_r + 8'h01;
    end
    // snapshot taken live: the bench holds config still around a fetch
    always_ff @(posedge clk) begin
        if (!rst_n) cnt_r <= 16'h0000;
        else if (take) cnt_r <= (fetch_len < dlen) ? fetch_len : dlen;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_HOLD: assert property (byte_valid && !byte_ready |=> byte_valid &&
        $stable(byte_data) && $stable(byte_last)) else $error("byte moved");
    AST_DROP: assert property (byte_valid && byte_ready |=> !byte_valid)
        else $error("valid held after accept");
    AST_FIRST: assert property (take |=> fetch_busy && !byte_valid
        ##1 !byte_valid ##1 byte_valid) else $error("first byte late");
    AST_LEN: assert property (byte_valid && idx_r == 8'h00
        |-> byte_data == desc_length) else $error("length byte");
    AST_TYPE: assert property (byte_valid && idx_r == 8'h01
        |-> byte_data == 8'h29) else $error("type byte");
    AST_CHAR: assert property (byte_valid && idx_r == 8'h03
        |-> {byte_data[7:5], byte_data[2:0]} == {cfg_port_ind, cfg_tt_think,
        cfg_compound, cfg_power_mode}) else $error("characteristics");
    AST_OC: assert property (byte_valid && idx_r == 8'h03
        |-> byte_data[4:3] == ((cfg_oc_mode[1] && !cfg_bus_powered) ? 2'h0
        : cfg_oc_mode)) else $error("over-current mode");
    AST_RSVD: assert property (byte_valid && idx_r == 8'h04
        |-> byte_data == 8'h00) else $error("reserved byte");
    AST_LAST: assert property (byte_valid
        |-> byte_last == ({8'h00, idx_r} + 16'h0001 == cnt_r))
        else $error("last flag");
    AST_IND: assert property (ind_apply |-> $past(ind_req) &&
        $past(cfg_port_ind) && ind_port == $past(ind_req_port))
        else $error("indicator");
    AST_DLEN: assert property ($past(rst_n) |-> desc_length ==
        8'(8 + $past(cfg_num_ports) / 8 + ($past(cfg_num_ports) + 7) / 8))
        else $error("descriptor length");
    AST_NPORTS: assert property (byte_valid && idx_r == 8'h02
        |-> byte_data == cfg_num_ports) else $error("port count");
    AST_PWR: assert property (byte_valid && idx_r == 8'h05
        |-> byte_data == cfg_pwr_good_time) else $error("power good time");
    AST_CUR: assert property (byte_valid && idx_r == 8'h06
        |-> byte_data == cfg_ctrl_current) else $error("controller current");
    AST_MAP0: assert property (byte_valid && idx_r == 8'h07
        |-> !byte_data[0]) else $error("reserved map bit");
    AST_MASK: assert property (byte_valid &&
        idx_r >= 8'h08 + (cfg_num_ports >> 3) |-> byte_data == 8'hFF)
        else $error("power mask");
endmodule // hds_desc_checker
bind hds_desc_source hds_desc_checker u_chk (.clk, .rst_n, .fetch_start,
    .byte_ready, .byte_valid, .byte_last, .fetch_busy, .cfg_compound,
    .cfg_port_ind, .cfg_bus_powered, .ind_req, .ind_apply, .cfg_power_mode,
    .cfg_oc_mode, .cfg_tt_think, .byte_data, .desc_length, .ind_req_port,
    .ind_port, .fetch_len, .cfg_num_ports, .cfg_pwr_good_time,
    .cfg_ctrl_current);

// >>> verif/hds_host_model.sv
`timescale 1ns/1ps
module hds_host_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      byte_ready
);
    // a slow host drops ready at random, so bytes must hold for a while
    always_ff @(posedge clk) begin
        if (!rst_n) byte_ready <= 1'b0;
        else byte_ready <= !slow || ($urandom % 3 == 0);
    end
endmodule // hds_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic         clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic         cfg_compound = 1'b0, cfg_bus_powered = 1'b0;
    logic         cfg_port_ind = 1'b0, fetch_start = 1'b0, ind_req = 1'b0;
    logic [1:0]   cfg_power_mode = 2'h0, cfg_oc_mode = 2'h0;
    logic [1:0]   cfg_tt_think = 2'h0;
    logic [7:0]   cfg_num_ports = 8'h01, cfg_pwr_good_time = 8'h00;
    logic [7:0]   cfg_ctrl_current = 8'h00, ind_req_port = 8'h00;
    logic [15:0]  fetch_len = 16'h0000, flen;
    logic [255:0] cfg_fixed_ports = 256'h0;
    logic         byte_ready, byte_valid, byte_last, fetch_busy, ind_apply;
    logic [7:0]   byte_data, desc_length, ind_port;
    logic [7:0]   ind_exp = 8'h00;
    int           mismatches = 0, checks_done = 0, cycles = 0;

    hds_desc_source #(.MAX_PORTS(255)) DUT (.clk, .rst_n, .cfg_num_ports,
        .cfg_power_mode, .cfg_compound, .cfg_oc_mode, .cfg_bus_powered,
        .cfg_tt_think, .cfg_port_ind, .cfg_pwr_good_time, .cfg_ctrl_current,
        .cfg_fixed_ports, .fetch_start, .fetch_len, .byte_ready, .byte_valid,
        .byte_data, .byte_last, .fetch_busy, .desc_length, .ind_req,
        .ind_req_port, .ind_apply, .ind_port);
    hds_host_model u_host (.clk, .rst_n, .slow, .byte_ready);

    always #4 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic check(string what, logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] exp_len();
        return 8'(8 + cfg_num_ports / 8 + (cfg_num_ports + 7) / 8);
    endfunction
    function automatic logic [7:0] exp_b(int i);
        int b;
        logic [7:0] v;
        v = 8'h00;
        case (i)
            0: return exp_len();
            1: return 8'h29;
            2: return cfg_num_ports;
            3: return {cfg_port_ind, cfg_tt_think,
                ((cfg_oc_mode[1] && !cfg_bus_powered) ? 2'h0 : cfg_oc_mode),
                cfg_compound, cfg_power_mode};
            4: return 8'h00;
            5: return cfg_pwr_good_time;
            6: return cfg_ctrl_current;
            default: v = 8'h00;
        endcase
        if (i >= 8 + cfg_num_ports / 8) return 8'hFF;
        for (int j = 0; j < 8; j++) begin
            b = (i - 7) * 8 + j;
            v[j] = b != 0 && b <= cfg_num_ports && cfg_fixed_ports[b];
        end
        return v;
    endfunction
    task automatic fetch(logic [15:0] len);
        int k;
        int want;
        k = 0;
        want = (len < exp_len()) ? len : exp_len();
        @(posedge clk);
        fetch_start <= 1'b1;
        fetch_len <= len;
        @(posedge clk);
        fetch_start <= 1'b0;
        for (int t = 0; t < 2000 && k < want; t++) begin
            @(negedge clk);
            if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
                check("byte", byte_data, exp_b(k));
                check("last", byte_last, k == want - 1);
                k++;
            end
        end
        @(negedge clk);
        check("count", 16'(k), 16'(want));
        check("busy", fetch_busy, 1'b0);
    endtask
    initial begin
        void'($urandom(32'h1c12));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int it = 0; it < 40; it++) begin
            @(posedge clk);
            cfg_num_ports <= (it == 0) ? 8'h01 : (it == 1) ? 8'hFF :
                (it == 2) ? 8'h08 : 8'($urandom_range(255, 1));
            {cfg_power_mode, cfg_compound, cfg_oc_mode, cfg_bus_powered,
                cfg_tt_think, cfg_port_ind} <= 9'($urandom);
            cfg_pwr_good_time <= 8'($urandom);
            cfg_ctrl_current <= 8'($urandom);
            for (int w = 0; w < 8; w++) cfg_fixed_ports[w*32 +: 32] <= $urandom;
            slow <= it % 2 == 1;
            // desc_length trails config by a cycle
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("length", desc_length, exp_len());
            flen = (it % 3 == 1) ? 16'h0002 : (it % 3 == 2) ? 16'hFFFF :
                16'($urandom_range(30, 1));
            fetch((it == 3) ? 16'h0000 : flen);
            // one cycle stands for one power-good unit
            repeat (cfg_pwr_good_time) @(posedge clk);
            @(posedge clk);
            ind_req <= 1'b1;
            ind_req_port <= 8'($urandom);
            @(posedge clk);
            ind_req <= 1'b0;
            @(negedge clk);
            check("apply", ind_apply, cfg_port_ind);
            if (cfg_port_ind) ind_exp = ind_req_port;
            check("port", ind_port, ind_exp);
        end
        stop_test();
    end
endmodule // tb_top
